/* File: sim/iep_partner.sv */
// core and timer flag model facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module iep_partner
    import iep_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic take_en,
    input wire logic [3:0] take_delay,
    input wire logic [1:0] tmr_set,
    input wire logic irq_to_core,
    input wire logic [15:0] irq_vector,
    input wire logic [N_SRC-1:0] hw_clear,
    output logic vec_take,
    output logic timer0_overflow,
    output logic timer1_overflow,
    output logic [15:0] got_vec,
    output logic [7:0] took_cnt
);
    logic [3:0] wait_ff; // cycles spent before accepting

    // timer flags: set on overflow, cleared by vectoring hardware
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
        end else begin
            timer0_overflow <= (timer0_overflow | tmr_set[0])
                & ~hw_clear[SRC_TIMER0];
            timer1_overflow <= (timer1_overflow | tmr_set[1])
                & ~hw_clear[SRC_TIMER1];
        end
    end

    // core: accept an offer after take_delay cycles, one-cycle pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vec_take <= 1'b0;
            wait_ff <= 4'h0;
            got_vec <= 16'h0000;
            took_cnt <= 8'h00;
        end else if (vec_take) begin
            // vector is whatever stands at the take edge
            vec_take <= 1'b0;
            wait_ff <= 4'h0;
            if (irq_to_core) begin
                got_vec <= irq_vector;
                took_cnt <= took_cnt + 8'h01;
            end
        end else if (irq_to_core && take_en) begin
            // slow core answers only after its delay ran out
            if (wait_ff >= take_delay) begin
                vec_take <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end else begin
            wait_ff <= 4'h0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import iep_pkg::*;
();
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic ext0_pin = 1'b1;
    logic ext1_pin = 1'b1;
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_overflow = 1'b0;
    logic timer2_external_flag = 1'b0;
    logic uart_rx_flag = 1'b0;
    logic uart_tx_flag = 1'b0;
    logic vec_take;
    logic reti = 1'b0;
    logic irq_to_core;
    logic [15:0] irq_vector;
    logic [N_SRC-1:0] hw_clear;
    logic event_irq;
    logic take_en = 1'b0; // core willing to accept
    logic [3:0] take_delay = 4'h0; // core answer delay
    logic [1:0] tmr_set = 2'b00; // timer overflow strobes
    logic [15:0] got_vec;
    logic [7:0] took_cnt;
    int miscompares = 0;
    int checks_done = 0;
    // expected vectors in fixed polling order
    logic [15:0] vec_tab [N_SRC] = '{16'h0003, 16'h000b, 16'h0013,
        16'h001b, 16'h0023, 16'h002b};

    iep_top dut_u (
        .clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext0_pin(ext0_pin), .ext1_pin(ext1_pin),
        .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow),
        .timer2_overflow(timer2_overflow),
        .timer2_external_flag(timer2_external_flag),
        .uart_rx_flag(uart_rx_flag), .uart_tx_flag(uart_tx_flag),
        .vec_take(vec_take), .reti(reti), .irq_to_core(irq_to_core),
        .irq_vector(irq_vector), .hw_clear(hw_clear),
        .event_irq(event_irq)
    );

    iep_partner partner_u (
        .clock(clock), .resetn(resetn), .take_en(take_en),
        .take_delay(take_delay), .tmr_set(tmr_set),
        .irq_to_core(irq_to_core), .irq_vector(irq_vector),
        .hw_clear(hw_clear), .vec_take(vec_take),
        .timer0_overflow(timer0_overflow),
        .timer1_overflow(timer1_overflow),
        .got_vec(got_vec), .took_cnt(took_cnt)
    );

    // 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    // verdict and end of run
    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // compare one value, count it, report a mismatch
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clock);
        n = 0;
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= w;
        read <= ~w;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 20) miscompares++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, {24'h00_0000, e}, q);
    endtask

    // let the core accept one offer and compare its vector
    task automatic take(input logic [15:0] v);
        logic [7:0] c0;
        int n;
        @(posedge clock);
        c0 = took_cnt;
        n = 0;
        take_en <= 1'b1;
        while (took_cnt === c0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        take_en <= 1'b0;
        chk("offer taken", 32'h0000_0001, {31'h0, n < 40});
        chk("vector", {16'h0000, v}, {16'h0000, got_vec});
    endtask

    // no offer may appear for k cycles
    task automatic no_irq(input int k);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            @(posedge clock);
            seen = seen | (irq_to_core !== 1'b0);
        end
        chk("no offer", 32'h0000_0000, {31'h0, seen});
    endtask

    task automatic ret();
        @(posedge clock);
        reti <= 1'b1;
        @(posedge clock);
        reti <= 1'b0;
    endtask

    task automatic kick(input logic [1:0] m);
        @(posedge clock);
        tmr_set <= m;
        @(posedge clock);
        tmr_set <= 2'b00;
    endtask

    task automatic evt(input logic e);
        @(posedge clock);
        chk("event line", {31'h0, e}, {31'h0, event_irq});
    endtask

    // reset values, reserved bits, unmapped offset
    task automatic check_regs();
        rd("ie reset", ADDR_IE, 8'h00);
        rd("ip reset", ADDR_IP, 8'h00);
        rd("status reset", ADDR_STAT, 8'h00);
        wr(ADDR_IE, 8'hff);
        rd("ie bits", ADDR_IE, 8'hbf);
        wr(ADDR_IP, 8'hff);
        rd("ip bits", ADDR_IP, 8'h3f);
        wr(ADDR_IE, 8'h00);
        wr(ADDR_IP, 8'h00);
        wr(8'h20, 8'hff);
        rd("unmapped", 8'h20, 8'h00);
    endtask

    // source enable without global enable, and the reverse
    task automatic check_gating();
        kick(2'b10);
        wr(ADDR_IE, 8'h08);
        no_irq(6);
        wr(ADDR_IE, 8'h80);
        no_irq(6);
        wr(ADDR_IE, 8'h88);
        take(16'h001b);
        ret();
        wr(ADDR_IE, 8'h00);
    endtask

    // all six at once, same level: granted in fixed order
    task automatic check_order();
        @(posedge clock);
        ext0_pin <= 1'b0;
        ext1_pin <= 1'b0;
        uart_rx_flag <= 1'b1;
        timer2_overflow <= 1'b1;
        kick(2'b11);
        wr(ADDR_IE, 8'hbf);
        for (int i = 0; i < N_SRC; i++) begin
            take(vec_tab[i]);
            @(posedge clock);
            if (i == SRC_EXT0) ext0_pin <= 1'b1;
            if (i == SRC_EXT1) ext1_pin <= 1'b1;
            if (i == SRC_UART) uart_rx_flag <= 1'b0;
            if (i == SRC_TIMER2) timer2_overflow <= 1'b0;
            ret();
        end
        wr(ADDR_IE, 8'h00);
    endtask

    // transmit flag and timer2 external flag raise merged requests
    task automatic check_merge();
        @(posedge clock);
        uart_tx_flag <= 1'b1;
        timer2_external_flag <= 1'b1;
        wr(ADDR_IE, 8'hb0);
        take(16'h0023);
        rd("raw flags", ADDR_FLAGS, 8'h30);
        rd("core state", ADDR_CORE, 8'h14);
        @(posedge clock);
        uart_tx_flag <= 1'b0;
        ret();
        take(16'h002b);
        @(posedge clock);
        timer2_external_flag <= 1'b0;
        ret();
        wr(ADDR_IE, 8'h00);
    endtask

    // nesting: high preempts low, equal levels never preempt
    task automatic check_preempt();
        wr(ADDR_IP, 8'h30);
        wr(ADDR_IE, 8'hbf);
        kick(2'b01);
        take(16'h000b);
        kick(2'b10);
        no_irq(8);
        @(posedge clock);
        timer2_overflow <= 1'b1;
        take_delay <= 4'h3;
        take(16'h002b);
        @(posedge clock);
        uart_rx_flag <= 1'b1;
        take_delay <= 4'h0;
        no_irq(8);
        @(posedge clock);
        timer2_overflow <= 1'b0;
        ret();
        take(16'h0023);
        @(posedge clock);
        uart_rx_flag <= 1'b0;
        ret();
        no_irq(8);
        ret();
        take(16'h001b);
        ret();
        wr(ADDR_IE, 8'h00);
        wr(ADDR_IP, 8'h00);
    endtask

    // pin held low: edge mode fires once, level mode again
    task automatic check_trigger();
        wr(ADDR_TRIG, 8'h01);
        wr(ADDR_IE, 8'h81);
        @(posedge clock);
        ext0_pin <= 1'b0;
        take(16'h0003);
        ret();
        no_irq(8);
        wr(ADDR_TRIG, 8'h00);
        take(16'h0003);
        @(posedge clock);
        ext0_pin <= 1'b1;
        ret();
        no_irq(6);
        wr(ADDR_IE, 8'h00);
    endtask

    // sticky status, mask onto the event line, write-one clear
    task automatic check_status();
        rd("status", ADDR_STAT, 8'h3f);
        evt(1'b0);
        wr(ADDR_MASK, 8'h02);
        evt(1'b1);
        wr(ADDR_CLR, 8'h02);
        evt(1'b0);
        rd("status cleared", ADDR_STAT, 8'h3d);
        rd("clear reads", ADDR_CLR, 8'h00);
        rd("mask", ADDR_MASK, 8'h02);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        check_regs();
        check_gating();
        check_order();
        check_merge();
        check_preempt();
        check_trigger();
        check_status();
        results();
    end

    // watchdog: far beyond the few hundred cycles needed
    initial begin
        #200_000;
        miscompares++;
        results();
    end
endmodule
`default_nettype wire

/* File: src/iep_ext_trig.sv */
// external request: level or falling-edge trigger
`timescale 1ns/1ps
`default_nettype none
module iep_ext_trig
    import iep_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin,
    input wire logic trigger_type,
    input wire logic clear,
    output logic request
);
    logic pin_d_ff; // previous pin level
    logic flag_ff; // latched transition
    logic fall; // high-to-low seen
    logic nxt_flag;

    assign fall = pin_d_ff & ~pin;
    // set beats the vectoring clear
    assign nxt_flag = fall | (flag_ff & ~clear);
    // low level or latched edge, by type
    assign request = trigger_type ? flag_ff : ~pin; // RULE5

    // pin history and edge flag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_d_ff <= 1'b1;
            flag_ff <= 1'b0;
        end else begin
            pin_d_ff <= pin;
            flag_ff <= nxt_flag; // RULE5
        end
    end

    property p_level_mode;
        @(posedge clock) disable iff (!resetn)
        !trigger_type |-> (request == !pin);
    endproperty
    a_level_mode: assert property (p_level_mode) // RULE5
        else $error("level mode request not equal to low pin");

    property p_edge_mode;
        @(posedge clock) disable iff (!resetn)
        trigger_type && pin_d_ff && !pin |=> request;
    endproperty
    a_edge_mode: assert property (p_edge_mode) // RULE5
        else $error("falling edge did not raise request");
endmodule
`default_nettype wire

/* File: src/iep_pkg.sv */
// package: constants and types of the interrupt enable/priority block
//
// Functional notes
// RULE1: global enable gates all; then per-source enable
// RULE2: enable bits 0..5: ext0,t0,ext1,t1,uart,t2
// RULE3: vector per source, 0003H step 8
// RULE4: software keeps external pin latches at one
// RULE5: trigger type 0 level, 1 falling transition
// RULE6: priority bit one puts source high level
// RULE7: no preemption by lower or equal level
// RULE8: same level resolved by fixed source order
// RULE9: software writes no ones to reserved bits
// RULE10: uart rx/tx and timer2 flags each ORed
// RULE11: in-service flag per level, cleared by return
package iep_pkg;
    // source count and indices, polling order
    localparam int N_SRC = 6;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_UART = 4;
    localparam int SRC_TIMER2 = 5;
    // global enable position in the enable register
    localparam int GLB_BIT = 7;
    // byte offsets on the register bus
    localparam logic [7:0] ADDR_IE = 8'h00;
    localparam logic [7:0] ADDR_IP = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_CLR = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_CORE = 8'h1c;
    // reset values and implemented bits
    localparam logic [7:0] IE_RST = 8'h00;
    localparam logic [7:0] IP_RST = 8'h00;
    localparam logic [7:0] IE_WMASK = 8'hbf;
    localparam logic [7:0] IP_WMASK = 8'h3f;
    // vector of source 0 and spacing between vectors
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // sources whose flag hardware clears on vectoring
    localparam logic [5:0] HWCLR_MASK = 6'h0f;
    // result of the priority resolution
    typedef struct packed {
        logic valid;
        logic high;
        logic [2:0] idx;
    } iep_grant_type;
endpackage

/* File: src/iep_resolve.sv */
// two-level priority resolution with fixed order
`timescale 1ns/1ps
`default_nettype none
module iep_resolve
    import iep_pkg::*;
(
    input wire logic [N_SRC-1:0] req,
    input wire logic [N_SRC-1:0] level,
    input wire logic busy_hi,
    input wire logic busy_lo,
    output iep_grant_type grant
);
    logic [N_SRC-1:0] hi_req; // enabled high-level
    logic [N_SRC-1:0] lo_req; // enabled low-level
    logic [N_SRC-1:0] sel; // level that competes
    logic any_hi;

    assign hi_req = req & level; // RULE6
    assign lo_req = req & ~level;
    assign any_hi = |hi_req;
    assign sel = any_hi ? hi_req : lo_req;

    // pick lowest index; block by in-service level
    always_comb begin
        grant = '0;
        grant.high = any_hi;
        // high only blocked by high; low by either
        if (any_hi) begin
            grant.valid = ~busy_hi; // RULE7
        end else begin
            grant.valid = (|lo_req) & ~busy_hi & ~busy_lo; // RULE7
        end
        // descending scan so lowest index wins
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (sel[i]) begin
                grant.idx = 3'(i); // RULE8
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/iep_top.sv */
// interrupt enable and priority controller, avalon slave
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module iep_top
    import iep_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    input wire logic timer2_external_flag,
    input wire logic uart_rx_flag,
    input wire logic uart_tx_flag,
    input wire logic vec_take,
    input wire logic reti,
    output logic irq_to_core,
    output logic [15:0] irq_vector,
    output logic [N_SRC-1:0] hw_clear,
    output logic event_irq
);
    // bus handshake
    logic ack_ff; // second cycle of an access
    logic [31:0] readdata_ff;
    logic acc; // any request
    logic wr_ok; // write commits this edge
    logic rd_cap; // read data captured
    logic [31:0] rmux; // selected read value

    // register storage
    logic [7:0] ie_ff; // interrupt_enable
    logic [7:0] ip_ff; // interrupt_priority
    logic [1:0] trig_ff; // ext trigger types
    logic [N_SRC-1:0] stat_ff; // sticky vectored events
    logic [N_SRC-1:0] mask_ff; // event interrupt enable
    logic [N_SRC-1:0] nxt_stat;

    // address decode
    logic sel_ie;
    logic sel_ip;
    logic sel_trig;
    logic sel_stat;
    logic sel_clr;
    logic sel_mask;
    logic sel_flags;
    logic sel_core;

    // request path
    logic ext0_request;
    logic ext1_request;
    logic [N_SRC-1:0] src_req; // raw per-source
    logic [N_SRC-1:0] en_req; // after enables
    logic [N_SRC-1:0] same_lvl; // competitors of grant
    iep_grant_type grant;

    // core side state
    logic pend_ff; // request offered to core
    logic [2:0] src_ff; // offered source
    logic lvl_ff; // offered level, 1 high
    logic [15:0] vector_ff;
    logic in_hi_ff; // high-level service active
    logic in_lo_ff; // low-level service active
    logic [N_SRC-1:0] hw_clear_ff;
    logic take; // core accepts offer
    logic [N_SRC-1:0] take_oh; // accepted source
    logic nxt_in_hi;
    logic nxt_in_lo;
    logic [15:0] nxt_vector;

    // ---- avalon slave ----
    // one wait cycle on every access
    assign acc = read | write;
    assign waitrequest = acc & ~ack_ff;
    assign wr_ok = write & ack_ff;
    assign rd_cap = read & ~ack_ff;
    assign readdata = readdata_ff;

    assign sel_ie = (address == ADDR_IE);
    assign sel_ip = (address == ADDR_IP);
    assign sel_trig = (address == ADDR_TRIG);
    assign sel_stat = (address == ADDR_STAT);
    assign sel_clr = (address == ADDR_CLR);
    assign sel_mask = (address == ADDR_MASK);
    assign sel_flags = (address == ADDR_FLAGS);
    assign sel_core = (address == ADDR_CORE);

    // read mux; clear register and holes read zero
    assign rmux = sel_ie ? {24'h00_0000, ie_ff} :
        sel_ip ? {24'h00_0000, ip_ff} :
        sel_trig ? {30'h0000_0000, trig_ff} :
        sel_stat ? {26'h000_0000, stat_ff} :
        sel_mask ? {26'h000_0000, mask_ff} :
        sel_flags ? {26'h000_0000, src_req} :
        sel_core ? {26'h000_0000, in_hi_ff, in_lo_ff,
            pend_ff, src_ff} :
        32'h0000_0000;

    // handshake phase and read capture
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            readdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= acc & ~ack_ff;
            if (rd_cap) begin
                readdata_ff <= rmux;
            end
        end
    end

    // ---- configuration registers ----
    // reserved bits are never stored
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ie_ff <= IE_RST;
            ip_ff <= IP_RST;
            trig_ff <= 2'h0;
            mask_ff <= 6'h00;
        end else if (wr_ok) begin
            if (sel_ie) begin
                ie_ff <= writedata[7:0] & IE_WMASK; // RULE9
            end
            if (sel_ip) begin
                ip_ff <= writedata[7:0] & IP_WMASK; // RULE9
            end
            if (sel_trig) begin
                trig_ff <= writedata[1:0];
            end
            if (sel_mask) begin
                mask_ff <= writedata[N_SRC-1:0];
            end
        end
    end

    // ---- event status ----
    // vectoring sets; write-one clears; set wins
    assign nxt_stat = take_oh | (stat_ff &
        ~((wr_ok && sel_clr) ? writedata[N_SRC-1:0] : 6'h00));
    assign event_irq = |(stat_ff & mask_ff);

    // sticky status bits
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stat_ff <= 6'h00;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // ---- request sources ----
    // external 0 trigger
    iep_ext_trig u_ext0 (
        .clock(clock),
        .resetn(resetn),
        .pin(ext0_pin),
        .trigger_type(trig_ff[0]),
        .clear(take_oh[SRC_EXT0]),
        .request(ext0_request)
    );

    // external 1 trigger
    iep_ext_trig u_ext1 (
        .clock(clock),
        .resetn(resetn),
        .pin(ext1_pin),
        .trigger_type(trig_ff[1]),
        .clear(take_oh[SRC_EXT1]),
        .request(ext1_request)
    );

    // gather sources in polling order
    assign src_req[SRC_EXT0] = ext0_request;
    assign src_req[SRC_TIMER0] = timer0_overflow;
    assign src_req[SRC_EXT1] = ext1_request;
    assign src_req[SRC_TIMER1] = timer1_overflow;
    // shared requests
    assign src_req[SRC_UART] = uart_rx_flag | uart_tx_flag; // RULE10
    assign src_req[SRC_TIMER2] = timer2_overflow |
        timer2_external_flag; // RULE10

    // global then individual enables
    assign en_req = src_req & ie_ff[N_SRC-1:0] &
        {N_SRC{ie_ff[GLB_BIT]}}; // RULE1 RULE2

    // priority and order
    iep_resolve u_resolve (
        .req(en_req),
        .level(ip_ff[N_SRC-1:0]),
        .busy_hi(in_hi_ff),
        .busy_lo(in_lo_ff),
        .grant(grant)
    );

    // ---- vectoring to the core ----
    assign take = vec_take & pend_ff;
    assign take_oh = take ? (6'h01 << src_ff) : 6'h00;
    // vector = base + index times spacing
    assign nxt_vector = VEC_BASE +
        16'(16'(grant.idx) * VEC_STEP); // RULE3
    // set on vectoring, cleared by return
    assign nxt_in_hi = (take & lvl_ff) |
        (in_hi_ff & ~reti); // RULE11
    assign nxt_in_lo = (take & ~lvl_ff) |
        (in_lo_ff & ~(reti & ~in_hi_ff)); // RULE11
    assign irq_to_core = pend_ff;
    assign irq_vector = vector_ff;
    assign hw_clear = hw_clear_ff;

    // offer tracks resolution; dropped on take
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_ff <= 1'b0;
            src_ff <= 3'h0;
            lvl_ff <= 1'b0;
            vector_ff <= VEC_BASE;
        end else begin
            pend_ff <= grant.valid & ~take; // RULE1 RULE7
            src_ff <= grant.idx; // RULE8
            lvl_ff <= grant.high; // RULE6
            vector_ff <= nxt_vector; // RULE3
        end
    end

    // in-service levels and flag clear pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_hi_ff <= 1'b0;
            in_lo_ff <= 1'b0;
            hw_clear_ff <= 6'h00;
        end else begin
            in_hi_ff <= nxt_in_hi; // RULE11
            in_lo_ff <= nxt_in_lo; // RULE11
            hw_clear_ff <= take_oh & HWCLR_MASK;
        end
    end

    // ---- checks ----
    // competitors at the granted level
    assign same_lvl = en_req &
        (grant.high ? ip_ff[N_SRC-1:0] : ~ip_ff[N_SRC-1:0]);

    property p_global_off;
        @(posedge clock) disable iff (!resetn)
        !ie_ff[GLB_BIT] |=> !pend_ff;
    endproperty
    a_global_off: assert property (p_global_off) // RULE1
        else $error("offer raised with global enable off");

    property p_src_enabled;
        @(posedge clock) disable iff (!resetn)
        pend_ff |-> ($past(ie_ff) & (8'h01 << src_ff)) != 8'h00;
    endproperty
    a_src_enabled: assert property (p_src_enabled) // RULE2
        else $error("offered source was not enabled");

    property p_vector;
        @(posedge clock) disable iff (!resetn)
        pend_ff |-> irq_vector == VEC_BASE +
            16'(16'(src_ff) * VEC_STEP);
    endproperty
    a_vector: assert property (p_vector) // RULE3
        else $error("vector does not match source");

    property p_level;
        @(posedge clock) disable iff (!resetn)
        pend_ff |-> lvl_ff ==
            (($past(ip_ff) & (8'h01 << src_ff)) != 8'h00);
    endproperty
    a_level: assert property (p_level) // RULE6
        else $error("offer level differs from priority bit");

    property p_hi_blocks;
        @(posedge clock) disable iff (!resetn)
        in_hi_ff && $past(in_hi_ff) |-> !pend_ff;
    endproperty
    a_hi_blocks: assert property (p_hi_blocks) // RULE7
        else $error("request offered during high service");

    property p_lo_only_hi;
        @(posedge clock) disable iff (!resetn)
        pend_ff && $past(in_lo_ff) |-> lvl_ff;
    endproperty
    a_lo_only_hi: assert property (p_lo_only_hi) // RULE7
        else $error("low request preempted low service");

    property p_order;
        @(posedge clock) disable iff (!resetn)
        pend_ff |-> ($past(same_lvl) &
            ((6'h01 << src_ff) - 6'h01)) == 6'h00;
    endproperty
    a_order: assert property (p_order) // RULE8
        else $error("lower index request was passed over");

    property p_uart_or;
        @(posedge clock) disable iff (!resetn)
        uart_tx_flag && !uart_rx_flag && ie_ff[GLB_BIT] &&
            ie_ff[SRC_UART] && (en_req & 6'h0f) == 6'h00 &&
            ip_ff == 8'h00 && !in_hi_ff && !in_lo_ff && !vec_take
            |=> pend_ff && src_ff == 3'(SRC_UART);
    endproperty
    a_uart_or: assert property (p_uart_or) // RULE10
        else $error("uart transmit flag did not request");

    property p_take_sets;
        @(posedge clock) disable iff (!resetn)
        take && !reti |=> ($past(lvl_ff) ? in_hi_ff : in_lo_ff);
    endproperty
    a_take_sets: assert property (p_take_sets) // RULE11
        else $error("vectoring did not mark level in service");

    property p_reti_hi;
        @(posedge clock) disable iff (!resetn)
        reti && !take && in_hi_ff
            |=> !in_hi_ff && in_lo_ff == $past(in_lo_ff);
    endproperty
    a_reti_hi: assert property (p_reti_hi) // RULE11
        else $error("return did not end high service only");

    property p_bus_ack;
        @(posedge clock) disable iff (!resetn)
        acc && waitrequest |=> !waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("access waited more than one cycle");

    // main scenarios
    property p_cv_nest;
        @(posedge clock) disable iff (!resetn)
        in_lo_ff && take && lvl_ff;
    endproperty
    c_cv_nest: cover property (p_cv_nest);

    property p_cv_tie;
        @(posedge clock) disable iff (!resetn)
        pend_ff && $countones($past(same_lvl)) > 1;
    endproperty
    c_cv_tie: cover property (p_cv_tie);

    property p_cv_reti;
        @(posedge clock) disable iff (!resetn)
        reti && in_lo_ff && !in_hi_ff;
    endproperty
    c_cv_reti: cover property (p_cv_reti);
endmodule
`default_nettype wire
